// ### mag_regs_map.svh
// register offsets, field positions, reset values for the magnetometer register bank
// assumes avalon-mm byte offsets; each register is one 32-bit word at 4 * index
//
// Contract
// [RQ1] part code reads out only while power control bit zero is set
// [RQ2] read-only eight-bit part code at index 0x40
// [RQ3] index 0x41 reserved, reads zero, writes ignored
// [RQ4] x low: field bits 4:0 in 7:3, zeros 2:1, x self-test in bit 0
// [RQ5] x high: field bits 12:5, completing 13-bit signed x
// [RQ6] y low: field bits 4:0 in 7:3, zeros 2:1, y self-test in bit 0
// [RQ7] y high: field bits 12:5, completing 13-bit y
// [RQ8] z low: field bits 6:0 in 7:1, z self-test bit 0; next holds upper z
// [RQ9] hall low: bits 5:0 in 7:2, zero bit 1, data-ready in bit 0
// [RQ10] read-write xy repetition count, resets to zero
// [RQ11] read-write z repetition count, resets to zero
// [RQ12] unassigned indices from 0x53 read zero, writes ignored
`ifndef MAG_REGS_MAP_SVH
`define MAG_REGS_MAP_SVH

`define IDX_PART_ID      8'h40
`define IDX_RESERVED     8'h41
`define IDX_X_LOW        8'h42
`define IDX_X_HIGH       8'h43
`define IDX_Y_LOW        8'h44
`define IDX_Y_HIGH       8'h45
`define IDX_Z_LOW        8'h46
`define IDX_Z_HIGH       8'h47
`define IDX_HALL_LOW     8'h48
`define IDX_HALL_HIGH    8'h49
`define IDX_INT_FLAGS    8'h4A
`define IDX_POWER_CTRL   8'h4B
`define IDX_OP_CTRL      8'h4C
`define IDX_INT_ENABLES  8'h4D
`define IDX_INT_PIN      8'h4E
`define IDX_LOW_LIMIT    8'h4F
`define IDX_HIGH_LIMIT   8'h50
`define IDX_XY_REP       8'h51
`define IDX_Z_REP        8'h52
`define IDX_EVT_STATUS   8'h60
`define IDX_EVT_MASK     8'h61

`define RST_POWER_CTRL   8'h00
`define RST_OP_CTRL      8'h06
`define RST_INT_ENABLES  8'h07
`define RST_INT_PIN      8'h07
`define RST_LOW_LIMIT    8'h00
`define RST_HIGH_LIMIT   8'h00
`define RST_XY_REP       8'h00
`define RST_Z_REP        8'h00
`define RST_EVT_MASK     8'h00

`define POWER_BIT        0
`define THREE_WIRE_BIT   2
`define SOFT_RESET_MASK  8'h82
`define POWER_WR_MASK    8'h87
`define EVT_READY_BIT    0
`define EVT_FLAGS_BIT    1
`define EVT_COUNT        2

`endif

// ### mag_regs_pkg.sv
// types for the magnetometer register bank
// assumes mag_regs_map.svh supplies the numeric constants
package mag_regs_pkg;
	typedef enum logic [1:0] {
		bus_idle,
		bus_answer
	} bus_state_t;
endpackage : mag_regs_pkg

// ### mag_regs.sv
// magnetometer register bank behind an avalon-mm slave with waitrequest
// assumes measurement results arrive on mclk from the sensing engine, with a one-cycle
// result_valid strobe; each register sits in the low byte of its own word
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "mag_regs_map.svh"

module mag_regs #(
	parameter logic [7:0] PART_CODE = 8'hA5 // arbitrary neutral value
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// avalon-mm slave
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// measurement results from the engine
	input  wire logic        result_valid,
	input  wire logic [12:0] x_field,
	input  wire logic [12:0] y_field,
	input  wire logic [14:0] z_field,
	input  wire logic [13:0] hall_resistance,
	input  wire logic [2:0]  self_test_result,
	input  wire logic [7:0]  engine_flags,
	// controls to the engine
	output logic             power_on,
	output logic             three_wire_enable,
	output logic             soft_reset,
	output logic      [7:0]  op_mode,
	output logic      [7:0]  int_enables,
	output logic      [7:0]  int_pin_setup,
	output logic      [7:0]  low_limit,
	output logic      [7:0]  high_limit,
	output logic      [7:0]  xy_repetition_count,
	output logic      [7:0]  z_repetition_count,
	// interrupt
	output logic             irq
);

	mag_regs_pkg::bus_state_t state_q;
	logic [7:0]  index;
	logic        wr_take;
	logic        rd_take;
	logic [7:0]  rd_d;
	logic [12:0] x_q;
	logic [12:0] y_q;
	logic [14:0] z_q;
	logic [13:0] hall_q;
	logic [2:0]  st_q;
	logic        ready_q;
	logic [7:0]  flags_q;
	logic [7:0]  power_q;
	logic [1:0]  evt_status_q;
	logic [1:0]  evt_mask_q;
	logic [1:0]  evt_set;

	// word index; addresses with bits 1:0 set are unaligned and decode as the word
	assign index    = address[9:2];
	assign wr_take  = (state_q == mag_regs_pkg::bus_answer) && write && byteenable[0];
	assign rd_take  = (state_q == mag_regs_pkg::bus_idle) && read;
	assign evt_set  = {result_valid, result_valid};

	// one wait cycle per access keeps read data registered
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= mag_regs_pkg::bus_idle;
			waitrequest <= 1'b1;
		end else begin
			unique case (state_q)
				mag_regs_pkg::bus_idle: begin
					if (read || write) begin
						state_q     <= mag_regs_pkg::bus_answer;
						waitrequest <= 1'b0;
					end
				end
				mag_regs_pkg::bus_answer: begin
					state_q     <= mag_regs_pkg::bus_idle;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// result capture; data-ready sets with a new result, cleared by reading hall low
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			x_q     <= 13'h0000;
			y_q     <= 13'h0000;
			z_q     <= 15'h0000;
			hall_q  <= 14'h0000;
			st_q    <= 3'h7;
			ready_q <= 1'b0;
			flags_q <= 8'h00;
		end else begin
			if (result_valid) begin
				x_q     <= x_field;
				y_q     <= y_field;
				z_q     <= z_field;
				hall_q  <= hall_resistance;
				st_q    <= self_test_result;
				flags_q <= engine_flags;
			end
			// set wins over the read clear
			if (result_valid)
				ready_q <= 1'b1;
			else if (rd_take && index == `IDX_HALL_LOW)
				ready_q <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			power_q             <= `RST_POWER_CTRL;
			op_mode             <= `RST_OP_CTRL;
			int_enables         <= `RST_INT_ENABLES;
			int_pin_setup       <= `RST_INT_PIN;
			low_limit           <= `RST_LOW_LIMIT;
			high_limit          <= `RST_HIGH_LIMIT;
			xy_repetition_count <= `RST_XY_REP; // RQ10
			z_repetition_count  <= `RST_Z_REP; // RQ11
			evt_mask_q          <= 2'h0;
		end else if (wr_take) begin
			// unlisted indices, reserved and read-only ones fall through unchanged
			unique case (index)
				`IDX_POWER_CTRL:  power_q             <= writedata[7:0] & `POWER_WR_MASK;
				`IDX_OP_CTRL:     op_mode             <= writedata[7:0];
				`IDX_INT_ENABLES: int_enables         <= writedata[7:0];
				`IDX_INT_PIN:     int_pin_setup       <= writedata[7:0];
				`IDX_LOW_LIMIT:   low_limit           <= writedata[7:0];
				`IDX_HIGH_LIMIT:  high_limit          <= writedata[7:0];
				`IDX_XY_REP:      xy_repetition_count <= writedata[7:0]; // RQ10
				`IDX_Z_REP:       z_repetition_count  <= writedata[7:0]; // RQ11
				`IDX_EVT_MASK:    evt_mask_q          <= writedata[1:0];
				default: begin
				end // RQ3 RQ12
			endcase
		end else if (power_q[7] || power_q[1]) begin
			// soft reset bits self-clear after one cycle
			power_q <= power_q & ~`SOFT_RESET_MASK;
		end
	end

	// sticky event status, write one to clear, set wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			evt_status_q <= 2'h0;
		else if (wr_take && index == `IDX_EVT_STATUS)
			evt_status_q <= (evt_status_q & ~writedata[1:0]) | evt_set;
		else
			evt_status_q <= evt_status_q | evt_set;
	end

	// read mux
	always_comb begin
		rd_d = 8'h00;
		unique case (index)
			`IDX_PART_ID:     rd_d = power_q[`POWER_BIT] ? PART_CODE : 8'h00; // RQ1 RQ2
			`IDX_RESERVED:    rd_d = 8'h00; // RQ3
			`IDX_X_LOW:       rd_d = {x_q[4:0], 2'b00, st_q[0]}; // RQ4
			`IDX_X_HIGH:      rd_d = x_q[12:5]; // RQ5
			`IDX_Y_LOW:       rd_d = {y_q[4:0], 2'b00, st_q[1]}; // RQ6
			`IDX_Y_HIGH:      rd_d = y_q[12:5]; // RQ7
			`IDX_Z_LOW:       rd_d = {z_q[6:0], st_q[2]}; // RQ8
			`IDX_Z_HIGH:      rd_d = z_q[14:7]; // RQ8
			`IDX_HALL_LOW:    rd_d = {hall_q[5:0], 1'b0, ready_q}; // RQ9
			`IDX_HALL_HIGH:   rd_d = hall_q[13:6];
			`IDX_INT_FLAGS:   rd_d = flags_q;
			`IDX_POWER_CTRL:  rd_d = power_q;
			`IDX_OP_CTRL:     rd_d = op_mode;
			`IDX_INT_ENABLES: rd_d = int_enables;
			`IDX_INT_PIN:     rd_d = int_pin_setup;
			`IDX_LOW_LIMIT:   rd_d = low_limit;
			`IDX_HIGH_LIMIT:  rd_d = high_limit;
			`IDX_XY_REP:      rd_d = xy_repetition_count; // RQ10
			`IDX_Z_REP:       rd_d = z_repetition_count; // RQ11
			`IDX_EVT_STATUS:  rd_d = {6'h00, evt_status_q};
			`IDX_EVT_MASK:    rd_d = {6'h00, evt_mask_q};
			default:          rd_d = 8'h00; // RQ12
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			readdata <= 32'h0000_0000;
		else if (rd_take)
			readdata <= {24'h00_0000, rd_d};
	end

	// registered copies for the engine and the interrupt
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			power_on          <= 1'b0;
			three_wire_enable <= 1'b0;
			soft_reset        <= 1'b0;
			irq               <= 1'b0;
		end else begin
			power_on          <= power_q[`POWER_BIT];
			three_wire_enable <= power_q[`THREE_WIRE_BIT];
			soft_reset        <= power_q[7] | power_q[1];
			irq               <= |(evt_status_q & evt_mask_q);
		end
	end

endmodule : mag_regs

// ### mag_engine_model.sv
// sensing engine stand-in: one result strobe per fire request
// assumes fire is a one-cycle pulse from the bench on mclk
`timescale 1ns/1ns
module mag_engine_model #(
	parameter logic [14:0] V = 15'h0
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        fire,
	output logic             result_valid,
	output logic      [12:0] x_field,
	output logic      [12:0] y_field,
	output logic      [14:0] z_field,
	output logic      [13:0] hall_resistance,
	output logic      [2:0]  self_test_result,
	output logic      [7:0]  engine_flags
);
	// off the strobe the buses show inverted values, so a stray capture is seen
	wire logic [14:0] w = V ^ {15{!result_valid}};
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) result_valid <= 1'h0;
		else result_valid <= fire;
	end
	assign x_field = w[12:0];
	assign y_field = w[14:2];
	assign z_field = w;
	assign hall_resistance = w[13:0];
	assign self_test_result = w[2:0];
	assign engine_flags = w[7:0];
endmodule : mag_engine_model

// ### mag_regs_chk.sv
// checker for mag_regs: answer timing and read-out of the register map
// assumes byte address = 4 * index
`timescale 1ns/1ns
module mag_regs_chk #(
	parameter logic [7:0] PART_CODE = 8'hA5
) (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic [9:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        power_on,
	input wire logic [7:0]  xy_repetition_count
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wire logic [7:0] idx = address[9:2];
	wire logic       rd  = read && !waitrequest;
	wire logic       wr  = write && !waitrequest && byteenable[0];
	a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered");
	a_wait_short: assert property (!waitrequest |=> waitrequest)
		else $error("answer held too long");
	a_id_gated: assert property (rd && idx == 8'h40 |->
		readdata == {24'h0, power_on ? PART_CODE : 8'h0}) else $error("part code");
	a_rsvd_zero: assert property (rd && idx == 8'h41 |-> readdata == 32'h0)
		else $error("reserved not zero");
	a_unmapped_zero: assert property (rd && idx > 8'h52 && idx[7:1] != 7'h30 |->
		readdata == 32'h0) else $error("unmapped not zero");
	a_low_zeros: assert property (rd && (idx == 8'h42 || idx == 8'h44) |->
		readdata[2:1] == 2'h0) else $error("low bits not zero");
	a_hall_zero: assert property (rd && idx == 8'h48 |-> !readdata[1])
		else $error("hall bit one set");
	a_xy_rep: assert property (wr && idx == 8'h51 |=>
		xy_repetition_count == $past(writedata[7:0])) else $error("xy count");
	cover property (rd && idx == 8'h40 && power_on);
	cover property (wr && idx == 8'h51);
	cover property (rd && idx == 8'h48 && readdata[0]);
endmodule : mag_regs_chk

bind mag_regs mag_regs_chk #(.PART_CODE(PART_CODE)) chk (
	.mclk(mclk), .rst_b(rst_b), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .power_on(power_on),
	.xy_repetition_count(xy_repetition_count));

// ### tb_mag_regs.sv
// self-checking bench for mag_regs over avalon-mm
// assumes mag_engine_model feeds one result per fire
`timescale 1ns/1ns
`include "mag_regs_map.svh"
module tb_mag_regs;
	localparam logic [7:0]  CODE = 8'h5C; // arbitrary part code
	localparam logic [14:0] V    = 15'h5A3C;
	logic        mclk = 1'h0, rst_b = 1'h0, read = 1'h0, write = 1'h0, fire = 1'h0;
	logic [9:0]  address = 10'h0;
	logic [31:0] writedata = 32'h0, rd_q, readdata;
	logic [3:0]  byteenable = 4'hF;
	logic        waitrequest, irq, result_valid;
	logic [12:0] x_f, y_f;
	logic [14:0] z_f;
	logic [13:0] h_f;
	logic [2:0]  s_f;
	logic [7:0]  f_f, junk [3] = '{8'h41, 8'h53, 8'hFF};
	logic        pw_on, tw_en, s_rst;
	logic [7:0]  op_m, i_en, i_pin, lo_l, hi_l, xy_c, z_c;
	int          err_count = 0, total_checks = 0;
	always #5 mclk = ~mclk;
	mag_engine_model #(.V(V)) eng (.mclk(mclk), .rst_b(rst_b), .fire(fire),
		.result_valid(result_valid), .x_field(x_f), .y_field(y_f), .z_field(z_f),
		.hall_resistance(h_f), .self_test_result(s_f), .engine_flags(f_f));
	mag_regs #(.PART_CODE(CODE)) DUT (.mclk(mclk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .result_valid(result_valid),
		.x_field(x_f), .y_field(y_f), .z_field(z_f), .hall_resistance(h_f),
		.self_test_result(s_f), .engine_flags(f_f), .power_on(pw_on),
		.three_wire_enable(tw_en), .soft_reset(s_rst), .op_mode(op_m), .int_enables(i_en),
		.int_pin_setup(i_pin), .low_limit(lo_l), .high_limit(hi_l),
		.xy_repetition_count(xy_c), .z_repetition_count(z_c), .irq(irq));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task acc(input logic wr, input logic [7:0] i, input logic [7:0] wd);
		@(posedge mclk);
		address <= {i, 2'h0};
		writedata <= {24'h0, wd};
		read <= !wr;
		write <= wr;
		do @(posedge mclk); while (waitrequest !== 1'h0);
		rd_q = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask : acc
	task rd_chk(input logic [7:0] i, input logic [7:0] e);
		acc(1'h0, i, 8'h0);
		check(rd_q, {24'h0, e});
	endtask : rd_chk
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (2) @(posedge mclk);
		rst_b <= 1'h1;
		rd_chk(`IDX_XY_REP, 8'h0);
		rd_chk(`IDX_Z_REP, 8'h0);
		rd_chk(`IDX_PART_ID, 8'h0);
		check({op_m, i_en, i_pin, lo_l}, 32'h0607_0700);
		check({8'h0, hi_l, xy_c, z_c}, 32'h0);
		rd_chk(`IDX_OP_CTRL, 8'h06);
		rd_chk(`IDX_INT_ENABLES, 8'h07);
		rd_chk(`IDX_INT_PIN, 8'h07);
		// soft reset bits pulse once, only bits 7, 2, 1, 0 are writable
		acc(1'h1, `IDX_POWER_CTRL, 8'hFF);
		repeat (2) @(posedge mclk);
		check({29'h0, pw_on, tw_en, s_rst}, 32'h7);
		@(posedge mclk);
		check({29'h0, pw_on, tw_en, s_rst}, 32'h6);
		rd_chk(`IDX_POWER_CTRL, 8'h05);
		acc(1'h1, `IDX_PART_ID, 8'h0);
		rd_chk(`IDX_PART_ID, CODE);
		foreach (junk[k]) begin
			acc(1'h1, junk[k], 8'hFF);
			rd_chk(junk[k], 8'h0);
		end
		acc(1'h1, `IDX_XY_REP, 8'hFF);
		acc(1'h1, `IDX_Z_REP, 8'h5A);
		acc(1'h1, `IDX_OP_CTRL, 8'hC3);
		acc(1'h1, `IDX_INT_ENABLES, 8'h81);
		acc(1'h1, `IDX_INT_PIN, 8'h18);
		acc(1'h1, `IDX_LOW_LIMIT, 8'h24);
		acc(1'h1, `IDX_HIGH_LIMIT, 8'h42);
		// a write without the low byte lane must leave the register alone
		byteenable <= 4'hE;
		acc(1'h1, `IDX_XY_REP, 8'h11);
		byteenable <= 4'hF;
		check({op_m, i_en, i_pin, lo_l}, 32'hC381_1824);
		check({8'h0, hi_l, xy_c, z_c}, 32'h0042_FF5A);
		rd_chk(`IDX_HIGH_LIMIT, 8'h42);
		rd_chk(`IDX_XY_REP, 8'hFF);
		rd_chk(`IDX_Z_REP, 8'h5A);
		fire <= 1'h1;
		@(posedge mclk);
		fire <= 1'h0;
		rd_chk(`IDX_X_LOW, {V[4:0], 2'h0, V[0]});
		rd_chk(`IDX_X_HIGH, V[12:5]);
		rd_chk(`IDX_Y_LOW, {V[6:2], 2'h0, V[1]});
		rd_chk(`IDX_Y_HIGH, V[14:7]);
		rd_chk(`IDX_Z_LOW, {V[6:0], V[2]});
		rd_chk(`IDX_Z_HIGH, V[14:7]);
		rd_chk(`IDX_HALL_LOW, {V[5:0], 2'h1});
		rd_chk(`IDX_HALL_LOW, {V[5:0], 2'h0});
		rd_chk(`IDX_HALL_HIGH, V[13:6]);
		rd_chk(`IDX_INT_FLAGS, V[7:0]);
		check({31'h0, irq}, 32'h0);
		acc(1'h1, `IDX_EVT_MASK, 8'h1);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h1);
		rd_chk(`IDX_EVT_STATUS, 8'h3);
		acc(1'h1, `IDX_EVT_STATUS, 8'h3);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h0);
		print_verdict;
	end
	initial begin
		#20000;
		err_count++;
		print_verdict;
	end
endmodule : tb_mag_regs
